// file: rtl/wpss_pkg.sv
// Constants, register map and types of the power-state sequencer
//
// Notes on behaviour
// - Turn resources on or off from required set and per-resource enable/disable times.
// - Power-up order and content come from software registers, not fixed logic.
// - Loaded down-counters on the slow-clock rate time each regulator and switch.
// - Clock speed follows power state; slow clock used whenever it suffices.
// - Active powers everything required; regulators in PWM or burst mode by load current.
// - Entering doze turns off radio, analog front end, PLLs and ROMs.
// - Doze stops all main clocks; only the slow clock keeps the sequencer alive.
// - In doze the sequencer can wake the chip itself and return to active.
// - Entering doze puts external and baseband switching regulators into burst mode.
// - Power-down shuts every internal regulator and leaves no internal wake.
// - RAM clock runs only while the RAM is being accessed.
package wpss_pkg;

    localparam int NUM_RES = 8;
    localparam int RES_W   = 3;
    localparam int ADDR_W  = 8;

    // Timing: slow tick derived from the system clock
    localparam longint CLK_FREQ_HZ = 250000000;
    localparam longint SLOW_FREQ_HZ = 32768;
    localparam int     SLOW_DIV_CYC = int'(CLK_FREQ_HZ / SLOW_FREQ_HZ);

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ACT_MASK  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DOZE_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_WAKE      = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ORDER     = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CLKCFG    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_TIME0     = 8'h20;

    // Reset values
    localparam logic [NUM_RES-1:0] ACT_MASK_RST  = 8'hff;
    localparam logic [NUM_RES-1:0] DOZE_MASK_RST = 8'hc3;
    localparam logic [31:0]        ORDER_RST     = 32'h76543210;
    localparam logic [15:0]        TIME_RST      = 16'h0404;
    localparam logic [15:0]        WAKE_RST      = 16'h0000;
    localparam logic               CLKCFG_RST    = 1'b1;

    // Resource indices
    localparam int RES_CORE  = 0;
    localparam int RES_BBSW  = 1;
    localparam int RES_ROM   = 2;
    localparam int RES_PLL   = 3;
    localparam int RES_AFE   = 4;
    localparam int RES_RADIO = 5;
    localparam int RES_RAM   = 6;
    localparam int RES_IO    = 7;
    localparam logic [NUM_RES-1:0] DOZE_OFF_MASK = 8'h3c;

    // Field positions
    localparam int ORDER_FLD_W   = 4;
    localparam int TIME_UP_LSB   = 0;
    localparam int TIME_DN_LSB   = 8;
    localparam int TIME_FLD_W    = 8;
    localparam int STAT_PS_LSB   = 0;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_TGT_LSB  = 4;
    localparam int STAT_ON_LSB   = 8;
    localparam int STAT_CLK_LSB  = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PS_ACTIVE = 2'h0,
        PS_DOZE   = 2'h1,
        PS_PDN    = 2'h2
    } wpss_pstate_e;

    typedef enum logic [1:0] {
        SQ_STABLE = 2'h0,
        SQ_SCAN   = 2'h1,
        SQ_WAIT   = 2'h3,
        SQ_DONE   = 2'h2
    } wpss_seq_e;

    typedef enum logic [1:0] {
        CK_OFF  = 2'h0,
        CK_SLOW = 2'h1,
        CK_FAST = 2'h2
    } wpss_clk_e;

endpackage : wpss_pkg

// file: rtl/wpss_tick_div.sv
// Divider that makes the slow-clock rate enable pulse
`timescale 1ns/1ps
module wpss_tick_div #(
    parameter int DIV = 7629
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    output logic      tick_out
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        tick_d;

    always_comb begin
        tick_d = (cnt_q == 16'(DIV - 1));
        cnt_d  = tick_d ? 16'h0000 : cnt_q + 16'h0001;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            tick_out <= tick_d;
        end
    end
endmodule : wpss_tick_div

// file: rtl/wpss_res_timer.sv
// Per-resource enable/disable down-counter on the slow tick
`timescale 1ns/1ps
module wpss_res_timer (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       tick_in,
    input  wire logic       load_in,
    input  wire logic [7:0] value_in,
    output logic            busy_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_in) begin
            cnt_d = value_in;
        end else if (tick_in && cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_out = (cnt_q != 8'h00);
endmodule : wpss_res_timer

// file: rtl/wpss_top.sv
// Power-state sequencer with AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module wpss_top
    import wpss_pkg::*;
#(
    parameter int SLOW_DIV = SLOW_DIV_CYC
) (
    input  wire logic               MCLK_IN,
    input  wire logic               NRST_IN,
    input  wire logic [ADDR_W-1:0]  AXI_AWADDR_IN,
    input  wire logic               AXI_AWVALID_IN,
    output logic                    AXI_AWREADY_OUT,
    input  wire logic [31:0]        AXI_WDATA_IN,
    input  wire logic [3:0]         AXI_WSTRB_IN,
    input  wire logic               AXI_WVALID_IN,
    output logic                    AXI_WREADY_OUT,
    output logic [1:0]              AXI_BRESP_OUT,
    output logic                    AXI_BVALID_OUT,
    input  wire logic               AXI_BREADY_IN,
    input  wire logic [ADDR_W-1:0]  AXI_ARADDR_IN,
    input  wire logic               AXI_ARVALID_IN,
    output logic                    AXI_ARREADY_OUT,
    output logic [31:0]             AXI_RDATA_OUT,
    output logic [1:0]              AXI_RRESP_OUT,
    output logic                    AXI_RVALID_OUT,
    input  wire logic               AXI_RREADY_IN,
    input  wire logic               LOAD_HI_IN,
    input  wire logic               REG_RESTORE_IN,
    input  wire logic               RAM_REQ_IN,
    output logic [NUM_RES-1:0]      RES_EN_OUT,
    output logic                    REG_PWM_OUT,
    output logic                    MAIN_CLK_EN_OUT,
    output logic [1:0]              CLK_SEL_OUT,
    output logic                    RAM_CLK_EN_OUT,
    output logic [1:0]              PSTATE_OUT,
    output logic                    SEQ_BUSY_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                   aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0]      awaddr_q, awaddr_d;
    logic [31:0]            wdata_q, wdata_d;
    logic [3:0]             wstrb_q, wstrb_d;
    logic                   awrdy_d, wrdy_d, bvalid_d, arrdy_d, rvalid_d;
    logic [1:0]             bresp_d, rresp_d;
    logic [31:0]            rdata_d;
    logic                   wr_fire, wr_hit;
    logic [NUM_RES-1:0]     act_mask_q, act_mask_d, doze_mask_q, doze_mask_d;
    logic [15:0]            wake_q, wake_d;
    logic [31:0]            order_q, order_d;
    logic                   fast_en_q, fast_en_d;
    logic [15:0]            time_q [NUM_RES];
    logic [15:0]            time_d [NUM_RES];
    logic                   ctrl_wr;
    logic [1:0]             ctrl_val;

    logic                   load_meta_q, load_sync_q, rst_meta_q, rst_sync_q;
    logic                   tick;
    wpss_seq_e              sq_q, sq_d;
    wpss_pstate_e           ps_q, ps_d, tgt_q, tgt_d;
    logic [RES_W-1:0]       slot_q, slot_d, cur_q, cur_d;
    logic [NUM_RES-1:0]     on_q, on_d, want, ld, busy;
    logic [15:0]            wcnt_q, wcnt_d;
    logic [7:0]             ld_val;
    logic [RES_W-1:0]       res_of_slot;
    wpss_clk_e              clk_d;
    logic                   pwm_d, mclk_d, ram_d;
    logic [1:0]             clk_q;

    ////////////////////////////////////////////////////////////////////////////
    // Slow tick and per-resource counters
    wpss_tick_div #(.DIV(SLOW_DIV)) u_div (
        .clk_in   (MCLK_IN),
        .rst_n_in (NRST_IN),
        .tick_out (tick)
    );

    for (genvar g = 0; g < NUM_RES; g++) begin : g_tmr
        wpss_res_timer u_tmr (
            .clk_in   (MCLK_IN),
            .rst_n_in (NRST_IN),
            .tick_in  (tick),
            .load_in  (ld[g]),
            .value_in (ld_val),
            .busy_out (busy[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and configuration registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a, output logic hit);
        logic [31:0] r;
        r   = 32'h0000_0000;
        hit = 1'b1;
        case (a)
            OFF_CTRL:      r[1:0] = tgt_q;
            OFF_STATUS: begin
                r[STAT_PS_LSB +: 2]        = ps_q;
                r[STAT_BUSY_BIT]           = (sq_q != SQ_STABLE);
                r[STAT_TGT_LSB +: 2]       = tgt_q;
                r[STAT_ON_LSB +: NUM_RES]  = on_q;
                r[STAT_CLK_LSB +: 2]       = clk_q;
            end
            OFF_ACT_MASK:  r[NUM_RES-1:0] = act_mask_q;
            OFF_DOZE_MASK: r[NUM_RES-1:0] = doze_mask_q;
            OFF_WAKE:      r[15:0] = wake_q;
            OFF_ORDER:     r = order_q;
            OFF_CLKCFG:    r[0] = fast_en_q;
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NUM_RES; i++) begin
                    if (a == OFF_TIME0 + ADDR_W'(4 * i)) begin
                        r[15:0] = time_q[i];
                        hit     = 1'b1;
                    end
                end
            end
        endcase
        return r;
    endfunction : rd_mux

    always_comb begin
        logic        rhit;
        logic [31:0] wm;
        logic [31:0] rv;
        rhit        = 1'b0;
        wm          = 32'h0000_0000;
        rv          = 32'h0000_0000;
        aw_have_d   = aw_have_q;
        w_have_d    = w_have_q;
        awaddr_d    = awaddr_q;
        wdata_d     = wdata_q;
        wstrb_d     = wstrb_q;
        bvalid_d    = AXI_BVALID_OUT;
        bresp_d     = AXI_BRESP_OUT;
        rvalid_d    = AXI_RVALID_OUT;
        rresp_d     = AXI_RRESP_OUT;
        rdata_d     = AXI_RDATA_OUT;
        act_mask_d  = act_mask_q;
        doze_mask_d = doze_mask_q;
        wake_d      = wake_q;
        order_d     = order_q;
        fast_en_d   = fast_en_q;
        time_d      = time_q;
        ctrl_wr     = 1'b0;
        ctrl_val    = 2'h0;
        wr_hit      = 1'b1;
        if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
            aw_have_d = 1'b1;
            awaddr_d  = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
            w_have_d = 1'b1;
            wdata_d  = AXI_WDATA_IN;
            wstrb_d  = AXI_WSTRB_IN;
        end
        if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
            bvalid_d = 1'b0;
        end
        wr_fire = aw_have_q && w_have_q && !AXI_BVALID_OUT;
        if (wr_fire) begin
            case (awaddr_q)
                OFF_CTRL: begin
                    wm       = merge(32'h0000_0000, wdata_q, wstrb_q);
                    ctrl_wr  = wstrb_q[0];
                    ctrl_val = wm[1:0];
                end
                OFF_STATUS:    wr_hit = 1'b1;
                OFF_ACT_MASK: begin
                    wm         = merge({24'h000000, act_mask_q}, wdata_q, wstrb_q);
                    act_mask_d = wm[NUM_RES-1:0];
                end
                OFF_DOZE_MASK: begin
                    wm          = merge({24'h000000, doze_mask_q}, wdata_q, wstrb_q);
                    doze_mask_d = wm[NUM_RES-1:0];
                end
                OFF_WAKE: begin
                    wm     = merge({16'h0000, wake_q}, wdata_q, wstrb_q);
                    wake_d = wm[15:0];
                end
                OFF_ORDER:     order_d = merge(order_q, wdata_q, wstrb_q);
                OFF_CLKCFG: begin
                    wm        = merge({31'h0, fast_en_q}, wdata_q, wstrb_q);
                    fast_en_d = wm[0];
                end
                default: begin
                    wr_hit = 1'b0;
                    for (int i = 0; i < NUM_RES; i++) begin
                        if (awaddr_q == OFF_TIME0 + ADDR_W'(4 * i)) begin
                            wm        = merge({16'h0000, time_q[i]}, wdata_q, wstrb_q);
                            time_d[i] = wm[15:0];
                            wr_hit    = 1'b1;
                        end
                    end
                end
            endcase
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
            rvalid_d = 1'b0;
        end
        if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            rv       = rd_mux(AXI_ARADDR_IN, rhit);
            rvalid_d = 1'b1;
            rdata_d  = rv;
            rresp_d  = rhit ? RESP_OKAY : RESP_SLVERR;
        end
        awrdy_d = !aw_have_d && !bvalid_d;
        wrdy_d  = !w_have_d && !bvalid_d;
        arrdy_d = !rvalid_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        logic up;
        up          = (tgt_q == PS_ACTIVE);
        // doze drops radio, front end, PLLs, ROMs
        case (tgt_q)
            PS_ACTIVE: want = act_mask_q;
            PS_DOZE:   want = doze_mask_q & ~DOZE_OFF_MASK;
            default:   want = '0;
        endcase
        res_of_slot = order_q[ORDER_FLD_W * (up ? int'(slot_q) : NUM_RES - 1 - int'(slot_q))
                              +: RES_W];
        sq_d   = sq_q;
        ps_d   = ps_q;
        tgt_d  = tgt_q;
        slot_d = slot_q;
        cur_d  = cur_q;
        on_d   = on_q;
        wcnt_d = wcnt_q;
        ld     = '0;
        ld_val = 8'h00;
        case (sq_q)
            SQ_STABLE: begin
                if (ps_q == PS_PDN) begin
                    // only the outside restore leaves power-down
                    if (rst_sync_q) begin
                        tgt_d = PS_ACTIVE;
                    end
                end else if (ctrl_wr && ctrl_val <= 2'(PS_PDN)) begin
                    tgt_d = wpss_pstate_e'(ctrl_val);
                end else if (ps_q == PS_DOZE && wake_q != 16'h0000) begin
                    // self wake after programmed slow ticks
                    if (tick) begin
                        wcnt_d = wcnt_q + 16'h0001;
                    end
                    if (wcnt_q >= wake_q) begin
                        tgt_d = PS_ACTIVE;
                    end
                end
                // Target resets to active, so power-down must wait for the restore
                if ((ps_q != PS_PDN || rst_sync_q) && (tgt_d != ps_q || want != on_q)) begin
                    sq_d   = SQ_SCAN;
                    slot_d = '0;
                    wcnt_d = 16'h0000;
                end
            end
            SQ_SCAN: begin
                // switch the resource if required set differs
                cur_d = res_of_slot;
                if (want[res_of_slot] != on_q[res_of_slot]) begin
                    on_d[res_of_slot] = want[res_of_slot];
                    ld[res_of_slot]   = 1'b1;
                    ld_val = want[res_of_slot]
                           ? time_q[res_of_slot][TIME_UP_LSB +: TIME_FLD_W]
                           : time_q[res_of_slot][TIME_DN_LSB +: TIME_FLD_W];
                    sq_d   = SQ_WAIT;
                end else if (slot_q == RES_W'(NUM_RES - 1)) begin
                    sq_d = SQ_DONE;
                end else begin
                    slot_d = slot_q + 1'b1;
                end
            end
            SQ_WAIT: begin
                if (!busy[cur_q]) begin
                    if (slot_q == RES_W'(NUM_RES - 1)) begin
                        sq_d = SQ_DONE;
                    end else begin
                        slot_d = slot_q + 1'b1;
                        sq_d   = SQ_SCAN;
                    end
                end
            end
            SQ_DONE: begin
                // report only once every counter is idle
                if (busy == '0) begin
                    ps_d = tgt_q;
                    sq_d = SQ_STABLE;
                end
            end
            default: sq_d = SQ_STABLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clocks and regulator modes
    always_comb begin
        // off unless target is active; fast only when active, settled, enabled and heavily loaded, else slow
        if (ps_q == PS_ACTIVE && tgt_q == PS_ACTIVE && sq_q == SQ_STABLE) begin
            clk_d = (fast_en_q && load_sync_q) ? CK_FAST : CK_SLOW;
        end else if (tgt_q == PS_ACTIVE) begin
            clk_d = CK_SLOW;
        end else begin
            clk_d = CK_OFF;
        end
        mclk_d = (clk_d != CK_OFF);
        // PWM when target is active and heavily loaded, burst otherwise
        pwm_d  = (tgt_q == PS_ACTIVE) && load_sync_q;
        ram_d  = RAM_REQ_IN && mclk_d && on_q[RES_RAM];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            aw_have_q       <= 1'b0;
            w_have_q        <= 1'b0;
            awaddr_q        <= '0;
            wdata_q         <= 32'h0000_0000;
            wstrb_q         <= 4'h0;
            AXI_AWREADY_OUT <= 1'b0;
            AXI_WREADY_OUT  <= 1'b0;
            AXI_BVALID_OUT  <= 1'b0;
            AXI_BRESP_OUT   <= RESP_OKAY;
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT  <= 1'b0;
            AXI_RRESP_OUT   <= RESP_OKAY;
            AXI_RDATA_OUT   <= 32'h0000_0000;
            act_mask_q      <= ACT_MASK_RST;
            doze_mask_q     <= DOZE_MASK_RST;
            wake_q          <= WAKE_RST;
            order_q         <= ORDER_RST;
            fast_en_q       <= CLKCFG_RST;
            for (int i = 0; i < NUM_RES; i++) begin
                time_q[i] <= TIME_RST;
            end
            load_meta_q     <= 1'b0;
            load_sync_q     <= 1'b0;
            rst_meta_q      <= 1'b0;
            rst_sync_q      <= 1'b0;
            sq_q            <= SQ_STABLE;
            ps_q            <= PS_PDN;
            tgt_q           <= PS_ACTIVE;
            slot_q          <= '0;
            cur_q           <= '0;
            on_q            <= '0;
            wcnt_q          <= 16'h0000;
            clk_q           <= CK_OFF;
            RES_EN_OUT      <= '0;
            REG_PWM_OUT     <= 1'b0;
            MAIN_CLK_EN_OUT <= 1'b0;
            CLK_SEL_OUT     <= CK_OFF;
            RAM_CLK_EN_OUT  <= 1'b0;
            PSTATE_OUT      <= PS_PDN;
            SEQ_BUSY_OUT    <= 1'b0;
        end else begin
            aw_have_q       <= aw_have_d;
            w_have_q        <= w_have_d;
            awaddr_q        <= awaddr_d;
            wdata_q         <= wdata_d;
            wstrb_q         <= wstrb_d;
            AXI_AWREADY_OUT <= awrdy_d;
            AXI_WREADY_OUT  <= wrdy_d;
            AXI_BVALID_OUT  <= bvalid_d;
            AXI_BRESP_OUT   <= bresp_d;
            AXI_ARREADY_OUT <= arrdy_d;
            AXI_RVALID_OUT  <= rvalid_d;
            AXI_RRESP_OUT   <= rresp_d;
            AXI_RDATA_OUT   <= rdata_d;
            act_mask_q      <= act_mask_d;
            doze_mask_q     <= doze_mask_d;
            wake_q          <= wake_d;
            order_q         <= order_d;
            fast_en_q       <= fast_en_d;
            time_q          <= time_d;
            load_meta_q     <= LOAD_HI_IN;
            load_sync_q     <= load_meta_q;
            rst_meta_q      <= REG_RESTORE_IN;
            rst_sync_q      <= rst_meta_q;
            sq_q            <= sq_d;
            ps_q            <= ps_d;
            tgt_q           <= tgt_d;
            slot_q          <= slot_d;
            cur_q           <= cur_d;
            on_q            <= on_d;
            wcnt_q          <= wcnt_d;
            clk_q           <= clk_d;
            RES_EN_OUT      <= on_d;
            REG_PWM_OUT     <= pwm_d;
            MAIN_CLK_EN_OUT <= mclk_d;
            CLK_SEL_OUT     <= clk_d;
            RAM_CLK_EN_OUT  <= ram_d;
            PSTATE_OUT      <= ps_d;
            SEQ_BUSY_OUT    <= (sq_d != SQ_STABLE);
        end
    end

endmodule : wpss_top

// file: testbench/wpss_props.sv
// Port checks of the power-state sequencer
`timescale 1ns/1ps
module wpss_props
    import wpss_pkg::*;
(
    input wire logic       MCLK_IN,
    input wire logic       NRST_IN,
    input wire logic       REG_RESTORE_IN,
    input wire logic       RAM_REQ_IN,
    input wire logic [7:0] RES_EN_OUT,
    input wire logic       REG_PWM_OUT,
    input wire logic       MAIN_CLK_EN_OUT,
    input wire logic [1:0] CLK_SEL_OUT,
    input wire logic       RAM_CLK_EN_OUT,
    input wire logic [1:0] PSTATE_OUT,
    input wire logic       SEQ_BUSY_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!NRST_IN);
    ram_gate_a: assert property (RAM_CLK_EN_OUT |-> $past(RAM_REQ_IN))
        else $error("RAM clock without access");
    doze_off_a: assert property ($rose(PSTATE_OUT == PS_DOZE) |-> !(|RES_EN_OUT[5:2]))
        else $error("Doze with radio side on");
    doze_clk_a: assert property ($rose(PSTATE_OUT == PS_DOZE) |->
        CLK_SEL_OUT == CK_OFF && !MAIN_CLK_EN_OUT)
        else $error("Doze with clocks on");
    doze_burst_a: assert property ($rose(PSTATE_OUT == PS_DOZE) |-> !REG_PWM_OUT)
        else $error("Doze in PWM mode");
    pdn_off_a: assert property ($rose(PSTATE_OUT == PS_PDN) |-> RES_EN_OUT == 8'h00)
        else $error("Power-down with resources on");
    pdn_hold_a: assert property ((PSTATE_OUT == PS_PDN && !REG_RESTORE_IN) [*4] |=>
        PSTATE_OUT == PS_PDN) else $error("Power-down left alone");
    state_late_a: assert property ($changed(PSTATE_OUT) |-> $past(SEQ_BUSY_OUT))
        else $error("State changed while idle");
    fast_act_a: assert property (CLK_SEL_OUT == CK_FAST |-> PSTATE_OUT == PS_ACTIVE)
        else $error("Fast clock outside active");
endmodule : wpss_props

// file: testbench/wpss_restore_model.sv
// Outside logic that re-enables the regulators on request
`timescale 1ns/1ps
module wpss_restore_model (
    input  wire logic       clk_in,
    input  wire logic       want_in,
    input  wire logic [3:0] slack_in,
    output logic            restore_out
);
    logic [3:0] cnt_q;
    initial restore_out = 1'b0;
    always @(posedge clk_in) begin
        cnt_q <= want_in ? cnt_q - 4'(cnt_q != 4'h0) : slack_in;
        restore_out <= want_in && cnt_q == 4'h0;
    end
endmodule : wpss_restore_model

// file: testbench/wlan_power_state_sequencer_test.sv
// Self-checking bench of the power-state sequencer
`timescale 1ns/1ps
module wlan_power_state_sequencer_test
    import wpss_pkg::*;
;
    logic        clk, nrst, awv, wv, brdy, arv, rrdy, ld, ram, want, rest, awr, wrd, bv, arr, rv;
    logic        busy;
    logic [7:0]  aa;
    logic [31:0] wd, rdat, tv;
    logic [1:0]  rr, ps, br;
    logic [3:0]  slack;
    logic [33:0] exp_q [$], msk_q [$];
    int          miscompares, checked, i;
    wpss_top #(.SLOW_DIV(4)) i_dut (.MCLK_IN(clk), .NRST_IN(nrst), .AXI_AWADDR_IN(aa),
        .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf),
        .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrd), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv),
        .AXI_BREADY_IN(brdy), .AXI_ARADDR_IN(aa), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
        .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rrdy),
        .LOAD_HI_IN(ld), .REG_RESTORE_IN(rest), .RAM_REQ_IN(ram), .RES_EN_OUT(), .REG_PWM_OUT(),
        .MAIN_CLK_EN_OUT(), .CLK_SEL_OUT(), .RAM_CLK_EN_OUT(), .PSTATE_OUT(ps), .SEQ_BUSY_OUT(busy));
    wpss_restore_model i_model (.clk_in(clk), .want_in(want), .slack_in(slack),
        .restore_out(rest));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) {ram, ld} <= 2'($urandom);
    always @(posedge clk) if (rv && rrdy) cmp({rr, rdat} & msk_q.pop_front(), exp_q.pop_front());
    always @(posedge clk) if (bv && brdy) cmp({32'h0, br}, {32'h0, RESP_OKAY});
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {aa, wd, awv, wv, brdy, arv, rrdy} <= {a, d, w, w, w, !w, !w};
        do begin
            @(posedge clk);
            {awv, wv, arv} <= {awv & !awr, wv & !wrd, arv & !arr};
        end while (!(bv && brdy || rv && rrdy));
        {brdy, rrdy} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m = '1);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_ps(input logic [1:0] s);
        for (int n = 0; n < 30000 && !(ps === s && busy === 1'b0); n++) @(posedge clk);
        if (!(ps === s && busy === 1'b0)) miscompares++;
    endtask : wait_ps
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {nrst, awv, wv, brdy, arv, rrdy, ld, ram, want, aa, wd, slack} = '0;
        void'($urandom(28834));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd(OFF_ACT_MASK, 34'hff);
        rd(8'h1c, 34'h200000000);
        for (i = 0; i < 8; i++) begin
            tv = $urandom & 32'h0f0f | 32'h0101;
            bus(1'b1, OFF_TIME0 + 8'(4 * i), tv);
            rd(OFF_TIME0 + 8'(4 * i), {2'h0, tv});
        end
        bus(1'b1, OFF_ORDER, 32'h01234567);
        rd(OFF_ORDER, 34'h01234567);
        want <= 1'b1;
        wait_ps(PS_ACTIVE);
        rd(OFF_STATUS, 34'hff00, 34'h30000ff37);
        $display("Power-up test done");
        bus(1'b1, OFF_CTRL, 32'h1);
        wait_ps(PS_DOZE);
        rd(OFF_STATUS, 34'hc311, 34'h30003ff37);
        bus(1'b1, OFF_WAKE, 32'h5);
        wait_ps(PS_ACTIVE);
        rd(OFF_STATUS, 34'hff00, 34'h30000ff37);
        $display("Doze test done");
        {slack, want} <= 5'h18;
        bus(1'b1, OFF_CTRL, 32'h2);
        wait_ps(PS_PDN);
        repeat (100) @(posedge clk);
        rd(OFF_STATUS, 34'h22, 34'h30003ff37);
        want <= 1'b1;
        wait_ps(PS_ACTIVE);
        rd(OFF_STATUS, 34'hff00, 34'h30000ff37);
        $display("Power-down test done");
        tally_and_finish();
    end
endmodule : wlan_power_state_sequencer_test
bind wpss_top wpss_props i_props (.MCLK_IN, .NRST_IN, .REG_RESTORE_IN, .RAM_REQ_IN, .RES_EN_OUT,
    .REG_PWM_OUT, .MAIN_CLK_EN_OUT, .CLK_SEL_OUT, .RAM_CLK_EN_OUT, .PSTATE_OUT, .SEQ_BUSY_OUT);
